// ==== rtl/tdma_slot_bit_framer.sv ====
// Purpose: bit-level slot and frame assembler for a test signal source
// Assumes: bit_tick paces bits; mode_sel is taken at each frame start
// Notes: a tick while the buffer is full emits nothing
// Notes on behaviour
// - pdc downlink traffic slot: ramp, lead-in, payload, sync, tag, steal, slow, payload
// - downlink sync pattern chosen by slot number 0, 1 or 2
// - colour tag, steal bit and slow control field are all zero
// - only pdc traffic slot 0 is sent; one payload sequence runs on unbroken across frames
// - no scrambling on pdc traffic payload, steal or slow fields
// - packet patterns use three-slot frames repeated every frame
// - four packet selections; unselected slots are not sent
// - packet payload pn9 runs on across sent slots and frames
// - downlink packet slot field order ending in 22 collision bits of ones
// - uplink packet slot with fixed sync, 116 payload, 18 zero guard
// - packet and phs slots are never scrambled
// - phs frame of eight slots; only one slot sent: slot 4 downlink, slot 0 uplink
// - unframed phs patterns: pn9, pn15 or zeros, no slots
// - phs sync pattern chosen by link direction
// - phs channel id zero, slow word 8000h, guard zero
// - phs crc covers channel id, slow word and payload
// - phs slot payload continues from frame to frame
// - markers give frame clock, rf gate and symbol clock
`timescale 1ns/1ps
module tdma_slot_bit_framer
	import tsbf_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// control
	input wire logic [3:0] mode_sel,
	input wire logic bit_tick,
	// modulator side
	input wire logic out_ready,
	output logic data_bit,
	output logic data_valid,
	// markers
	output logic mark_frame,
	output logic mark_gate,
	output logic mark_symbol
);
	typedef struct packed {
		tsbf_run_type st;
		logic [3:0] mode;
		logic [2:0] slot;
		logic [3:0] fidx;
		logic [7:0] fcnt;
		logic ph;
		logic [8:0] pn9;
		logic [14:0] pn15;
		logic [15:0] crc;
		logic [10:0] ucnt;
	} tsbf_state_type;

	tsbf_state_type s_q, s_d;
	tsbf_fld_type fld;
	tsbf_kind_type kind;
	logic [ITEM_W-1:0] item;
	logic [ITEM_W-1:0] head;
	logic buf_ready, buf_valid, push, unf, tx, fbit, pbit, slot_end;
	logic [2:0] last_slot;
	logic [7:0] bidx;
	logic [21:0] sync;

	// build one field descriptor
	function automatic tsbf_fld_type mk(tsbf_ftype_type ft,
		logic [7:0] len, logic [21:0] val, logic ci, logic last);
		tsbf_fld_type r;
		r.ft = ft;
		r.len = len;
		r.val = val;
		r.crc_in = ci;
		r.last = last;
		return r;
	endfunction

	// field table per slot kind
	function automatic tsbf_fld_type field_of(tsbf_kind_type k,
		logic [3:0] i, logic [21:0] sw);
		tsbf_fld_type r;
		r = mk(f_const, LEN_RAMP, VAL_ZERO, 1'b0, 1'b0);
		unique case (k)
			k_pdc_tch:
				case (i)
					4'h1: r = mk(f_const, LEN_LEAD, VAL_LEAD, 1'b0, 1'b0);
					4'h2: r = mk(f_pn, LEN_PDC_PAY, VAL_ZERO, 1'b0, 1'b0);
					4'h3: r = mk(f_sync, LEN_PDC_SYNC, sw, 1'b0, 1'b0);
					4'h4: r = mk(f_const, LEN_COLOUR, VAL_ZERO, 1'b0, 1'b0);
					4'h5: r = mk(f_const, LEN_STEAL, VAL_ZERO, 1'b0, 1'b0);
					4'h6: r = mk(f_const, LEN_SLOW_CTRL, VAL_ZERO, 1'b0,
						1'b0);
					4'h7: r = mk(f_pn, LEN_PDC_PAY, VAL_ZERO, 1'b0, 1'b1);
					default: r = mk(f_const, LEN_RAMP, VAL_ZERO, 1'b0, 1'b0);
				endcase
			k_pkt_dl:
				case (i)
					4'h1: r = mk(f_const, LEN_LEAD, VAL_LEAD, 1'b0, 1'b0);
					4'h2: r = mk(f_pn, LEN_PDC_PAY, VAL_ZERO, 1'b0, 1'b0);
					4'h3: r = mk(f_sync, LEN_PDC_SYNC, sw, 1'b0, 1'b0);
					4'h4: r = mk(f_const, LEN_COLOUR, VAL_ZERO, 1'b0, 1'b0);
					4'h5: r = mk(f_pn, LEN_PDC_PAY, VAL_ZERO, 1'b0, 1'b0);
					4'h6: r = mk(f_const, LEN_COLL, VAL_COLL, 1'b0, 1'b1);
					default: r = mk(f_const, LEN_RAMP, VAL_ZERO, 1'b0, 1'b0);
				endcase
			k_pkt_ul:
				case (i)
					4'h1: r = mk(f_const, LEN_LEAD, VAL_LEAD, 1'b0, 1'b0);
					4'h2: r = mk(f_pn, LEN_PDC_PAY, VAL_ZERO, 1'b0, 1'b0);
					4'h3: r = mk(f_sync, LEN_PDC_SYNC, sw, 1'b0, 1'b0);
					4'h4: r = mk(f_const, LEN_COLOUR, VAL_ZERO, 1'b0, 1'b0);
					4'h5: r = mk(f_pn, LEN_UL_PAY, VAL_ZERO, 1'b0, 1'b0);
					4'h6: r = mk(f_const, LEN_UL_GUARD, VAL_ZERO, 1'b0, 1'b1);
					default: r = mk(f_const, LEN_RAMP, VAL_ZERO, 1'b0, 1'b0);
				endcase
			k_phs:
				case (i)
					4'h1: r = mk(f_const, LEN_LEAD, VAL_LEAD, 1'b0, 1'b0);
					4'h2: r = mk(f_const, LEN_PHS_LEAD, VAL_PHS_LEAD, 1'b0,
						1'b0);
					4'h3: r = mk(f_sync, LEN_PHS_SYNC, sw, 1'b0, 1'b0);
					4'h4: r = mk(f_const, LEN_CHAN_ID, VAL_ZERO, 1'b1,
						1'b0);
					4'h5: r = mk(f_const, LEN_SLOW_WORD, VAL_SLOW_WORD, 1'b1,
						1'b0);
					4'h6: r = mk(f_pn, LEN_PHS_PAY, VAL_ZERO, 1'b1,
						1'b0);
					4'h7: r = mk(f_crc, LEN_CRC, VAL_ZERO, 1'b0, 1'b0);
					4'h8: r = mk(f_const, LEN_PHS_GUARD, VAL_ZERO, 1'b0,
						1'b1);
					default: r = mk(f_const, LEN_RAMP, VAL_ZERO, 1'b0, 1'b0);
				endcase
		endcase
		return r;
	endfunction

	// slot kind, frame length and sent slots from the mode
	always_comb
	begin
		kind = k_phs;
		last_slot = PHS_LAST_SLOT;
		tx = 1'b0;
		unf = 1'b0;
		case (s_q.mode)
			MODE_PDC_TCH:
			begin
				kind = k_pdc_tch;
				last_slot = PDC_LAST_SLOT;
				tx = (s_q.slot == 3'h0);
			end
			MODE_PKT_DL_0, MODE_PKT_DL_01, MODE_PKT_DL_ALL:
			begin
				kind = k_pkt_dl;
				last_slot = PDC_LAST_SLOT;
				tx = (s_q.mode == MODE_PKT_DL_ALL) ||
					(s_q.slot == 3'h0) ||
					(s_q.mode == MODE_PKT_DL_01 &&
					s_q.slot == 3'h1);
			end
			MODE_PKT_UL_0:
			begin
				kind = k_pkt_ul;
				last_slot = PDC_LAST_SLOT;
				tx = (s_q.slot == 3'h0);
			end
			MODE_PHS_DL:
				tx = (s_q.slot == PHS_TX_DL);
			MODE_PHS_UL:
				tx = (s_q.slot == PHS_TX_UL);
			default:
				unf = 1'b1;
		endcase
	end

	// sync pattern by slot number or link direction
	always_comb
	begin
		sync = SYNC_DL_S0;
		if (kind == k_phs)
			sync = (s_q.mode == MODE_PHS_DL) ? SYNC_PHS_DL :
				SYNC_PHS_UL;
		else if (kind == k_pkt_ul)
			sync = SYNC_UL_S0;
		else if (s_q.slot == 3'h1)
			sync = SYNC_DL_S1;
		else if (s_q.slot == 3'h2)
			sync = SYNC_DL_S2;
	end

	// current field and its bit
	always_comb
	begin
		fld = field_of(kind, s_q.fidx, sync);
		bidx = fld.len - 8'h01 - s_q.fcnt;
		unique case (fld.ft)
			f_pn: fbit = s_q.pn9[8];
			f_crc: fbit = ~s_q.crc[15];
			default: fbit = fld.val[bidx[4:0]];
		endcase
		if (s_q.mode == MODE_PHS_PN9)
			pbit = s_q.pn9[8];
		else if (s_q.mode == MODE_PHS_PN15)
			pbit = s_q.pn15[14];
		else
			pbit = 1'b0;
	end

	assign push = (s_q.st == st_run) & bit_tick & buf_ready;
	assign slot_end = (s_q.fcnt == fld.len - 8'h01) & fld.last;

	// sequencing, generators and output item
	always_comb
	begin
		s_d = s_q;
		item = '0;
		if (s_q.st == st_idle)
		begin
			s_d.mode = mode_sel;
			s_d.st = st_run;
		end
		else if (push && unf)
		begin
			item[ITEM_BIT] = pbit;
			item[ITEM_GATE] = 1'b1;
			item[ITEM_FRAME] = (s_q.ucnt == 11'h000);
			item[ITEM_SYM] = ~s_q.ph;
			s_d.ph = ~s_q.ph;
			if (s_q.mode == MODE_PHS_PN9)
				s_d.pn9 = {s_q.pn9[7:0], s_q.pn9[8] ^ s_q.pn9[4]};
			if (s_q.mode == MODE_PHS_PN15)
				s_d.pn15 = {s_q.pn15[13:0],
					s_q.pn15[14] ^ s_q.pn15[13]};
			s_d.ucnt = s_q.ucnt + 11'h001;
			if (s_q.ucnt == UNF_LAST)
			begin
				s_d.ucnt = '0;
				s_d.ph = 1'b0;
				s_d.mode = mode_sel;
			end
		end
		else if (push)
		begin
			item[ITEM_BIT] = tx & fbit;
			item[ITEM_GATE] = tx;
			item[ITEM_FRAME] = (s_q.slot == 3'h0) &&
				(s_q.fidx == 4'h0) && (s_q.fcnt == 8'h00);
			item[ITEM_SYM] = ~s_q.ph;
			s_d.ph = ~s_q.ph;
			// payload sequence only moves in sent slots
			if (tx && fld.ft == f_pn)
				s_d.pn9 = {s_q.pn9[7:0],
					s_q.pn9[8] ^ s_q.pn9[4]};
			if (tx && fld.crc_in)
				s_d.crc = {s_q.crc[14:0], 1'b0} ^
					((s_q.crc[15] ^ fbit) ? CRC_POLY :
					16'h0000);
			if (tx && fld.ft == f_crc)
				s_d.crc = {s_q.crc[14:0], 1'b0};
			s_d.fcnt = s_q.fcnt + 8'h01;
			if (s_q.fcnt == fld.len - 8'h01)
			begin
				s_d.fcnt = '0;
				s_d.fidx = s_q.fidx + 4'h1;
			end
			if (slot_end)
			begin
				s_d.fidx = '0;
				s_d.crc = CRC_PRESET;
				s_d.slot = s_q.slot + 3'h1;
				if (s_q.slot == last_slot)
				begin
					s_d.slot = '0;
					s_d.ph = 1'b0;
					s_d.ucnt = '0;
					s_d.mode = mode_sel;
				end
			end
		end
	end

	// state register
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			s_q <= '0;
			s_q.st <= st_idle;
			s_q.pn9 <= PN9_SEED;
			s_q.pn15 <= PN15_SEED;
			s_q.crc <= CRC_PRESET;
		end
		else
			s_q <= s_d;
	end

	// two-entry buffer toward the modulator
	tsbf_skid_buf #(
		.W(ITEM_W)
	) u_buf (
		.clk(clk),
		.rst(rst),
		.in_valid(push),
		.in_data(item),
		.in_ready(buf_ready),
		.out_valid(buf_valid),
		.out_data(head),
		.out_ready(out_ready)
	);

	// outputs from the buffer head register
	assign data_valid = buf_valid;
	assign data_bit = head[ITEM_BIT];
	assign mark_gate = head[ITEM_GATE];
	assign mark_frame = head[ITEM_FRAME];
	assign mark_symbol = head[ITEM_SYM];
endmodule // tdma_slot_bit_framer

// ==== rtl/tsbf_pkg.sv ====
// Purpose: constants and types of the slot bit framer
// Assumes: one clock, synchronous active-high reset
// Notes: all field values are shifted out msb first
package tsbf_pkg;
	// pattern selection codes on mode_sel
	localparam logic [3:0] MODE_PDC_TCH = 4'h0;
	localparam logic [3:0] MODE_PKT_DL_0 = 4'h1;
	localparam logic [3:0] MODE_PKT_DL_01 = 4'h2;
	localparam logic [3:0] MODE_PKT_DL_ALL = 4'h3;
	localparam logic [3:0] MODE_PKT_UL_0 = 4'h4;
	localparam logic [3:0] MODE_PHS_DL = 4'h5;
	localparam logic [3:0] MODE_PHS_UL = 4'h6;
	localparam logic [3:0] MODE_PHS_PN9 = 4'h7;
	localparam logic [3:0] MODE_PHS_PN15 = 4'h8;
	localparam logic [3:0] MODE_PHS_ZERO = 4'h9;
	// field lengths in bits
	localparam logic [7:0] LEN_RAMP = 8'h04;
	localparam logic [7:0] LEN_LEAD = 8'h02;
	localparam logic [7:0] LEN_PDC_PAY = 8'h70;
	localparam logic [7:0] LEN_PDC_SYNC = 8'h14;
	localparam logic [7:0] LEN_COLOUR = 8'h08;
	localparam logic [7:0] LEN_STEAL = 8'h01;
	localparam logic [7:0] LEN_SLOW_CTRL = 8'h15;
	localparam logic [7:0] LEN_COLL = 8'h16;
	localparam logic [7:0] LEN_UL_PAY = 8'h74;
	localparam logic [7:0] LEN_UL_GUARD = 8'h12;
	localparam logic [7:0] LEN_PHS_LEAD = 8'h06;
	localparam logic [7:0] LEN_PHS_SYNC = 8'h10;
	localparam logic [7:0] LEN_CHAN_ID = 8'h04;
	localparam logic [7:0] LEN_SLOW_WORD = 8'h10;
	localparam logic [7:0] LEN_PHS_PAY = 8'hA0;
	localparam logic [7:0] LEN_CRC = 8'h10;
	localparam logic [7:0] LEN_PHS_GUARD = 8'h10;
	// constant field values, zero extended
	localparam logic [21:0] VAL_ZERO = 22'h000000;
	localparam logic [21:0] VAL_LEAD = 22'h000002;
	localparam logic [21:0] VAL_PHS_LEAD = 22'h000019;
	localparam logic [21:0] VAL_SLOW_WORD = 22'h008000;
	localparam logic [21:0] VAL_COLL = 22'h3FFFFF;
	// sync patterns
	localparam logic [21:0] SYNC_DL_S0 = 22'h087A4B;
	localparam logic [21:0] SYNC_DL_S1 = 22'h09D236;
	localparam logic [21:0] SYNC_DL_S2 = 22'h081D75;
	localparam logic [21:0] SYNC_UL_S0 = 22'h0785B4;
	localparam logic [21:0] SYNC_PHS_UL = 22'h00E149;
	localparam logic [21:0] SYNC_PHS_DL = 22'h003D4C;
	// frame structure
	localparam logic [2:0] PDC_LAST_SLOT = 3'h2;
	localparam logic [2:0] PHS_LAST_SLOT = 3'h7;
	localparam logic [2:0] PHS_TX_UL = 3'h0;
	localparam logic [2:0] PHS_TX_DL = 3'h4;
	localparam logic [10:0] UNF_LAST = 11'h77F;
	// sequence generators
	localparam logic [8:0] PN9_SEED = 9'h1FF;
	localparam logic [14:0] PN15_SEED = 15'h7FFF;
	localparam logic [15:0] CRC_PRESET = 16'hFFFF;
	localparam logic [15:0] CRC_POLY = 16'h1021;
	// output item layout
	localparam int ITEM_W = 4;
	localparam int ITEM_BIT = 0;
	localparam int ITEM_SYM = 1;
	localparam int ITEM_GATE = 2;
	localparam int ITEM_FRAME = 3;

	typedef enum logic [1:0] {k_pdc_tch, k_pkt_dl, k_pkt_ul, k_phs}
		tsbf_kind_type;
	typedef enum logic [1:0] {f_const, f_pn, f_sync, f_crc}
		tsbf_ftype_type;
	typedef enum logic {st_idle, st_run} tsbf_run_type;
	typedef struct packed {
		tsbf_ftype_type ft;
		logic [7:0] len;
		logic [21:0] val;
		logic crc_in;
		logic last;
	} tsbf_fld_type;
endpackage

// ==== rtl/tsbf_skid_buf.sv ====
// Purpose: two-entry buffer between framer and modulator
// Assumes: in_ready low while the spare entry is occupied
// Notes: head entry is the registered output
`timescale 1ns/1ps
module tsbf_skid_buf #(
	parameter int W = 4
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// filling side
	input wire logic in_valid,
	input wire logic [W-1:0] in_data,
	output logic in_ready,
	// draining side
	output logic out_valid,
	output logic [W-1:0] out_data,
	input wire logic out_ready
);
	typedef struct packed {
		logic head_v;
		logic [W-1:0] head;
		logic spare_v;
		logic [W-1:0] spare;
	} tsbf_buf_type;

	tsbf_buf_type s_q, s_d;
	logic push, pop;

	// handshakes on both sides
	assign in_ready = ~s_q.spare_v;
	assign out_valid = s_q.head_v;
	assign out_data = s_q.head;
	assign push = in_valid & ~s_q.spare_v;
	assign pop = s_q.head_v & out_ready;

	// entry movement
	always_comb
	begin
		s_d = s_q;
		if (pop)
		begin
			if (s_q.spare_v)
			begin
				s_d.head = s_q.spare;
				s_d.spare_v = 1'b0;
			end
			else
			begin
				s_d.head_v = push;
				if (push)
					s_d.head = in_data;
			end
		end
		else if (push)
		begin
			if (!s_q.head_v)
			begin
				s_d.head_v = 1'b1;
				s_d.head = in_data;
			end
			else
			begin
				s_d.spare_v = 1'b1;
				s_d.spare = in_data;
			end
		end
	end

	// state register
	always_ff @(posedge clk)
	begin
		if (rst)
			s_q <= '0;
		else
			s_q <= s_d;
	end
endmodule // tsbf_skid_buf

// ==== tb/tsbf_properties.sv ====
// Purpose: port checks of the slot bit framer
// Assumes: sees only the framer ports
// Notes: bound at the foot of this file
`timescale 1ns/1ps
module tsbf_properties
	import tsbf_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// watched ports
	input wire logic bit_tick,
	input wire logic out_ready,
	input wire logic data_bit,
	input wire logic data_valid,
	input wire logic mark_frame,
	input wire logic mark_gate,
	input wire logic mark_symbol
);
	logic take, sym_q, gate_q, seen_q;
	logic [11:0] pos_q, idx;
	default clocking @(posedge clk);
	endclocking
	default disable iff (rst);
	// taken item and its index in the frame
	assign take = data_valid && out_ready;
	assign idx = mark_frame ? 12'h000 : pos_q;
	// markers of the last taken item
	always_ff @(posedge clk)
	begin
		if (rst)
			{sym_q, gate_q, seen_q, pos_q} <= '0;
		else if (take)
		begin
			sym_q <= mark_symbol;
			gate_q <= mark_gate;
			seen_q <= seen_q | mark_frame;
			pos_q <= idx + 12'h001;
		end
	end
	sequence s_stall;
		data_valid && !out_ready;
	endsequence
	property p_stands;
		s_stall |=> data_valid
			&& $stable({data_bit, mark_frame, mark_gate, mark_symbol});
	endproperty
	a_stands: assert property (p_stands) else $error("stall hold");
	// two empty cycles while the framer picks up its mode
	sequence s_quiet2;
		!data_valid ##1 !data_valid;
	endsequence
	property p_quiet;
		$fell(rst) |-> s_quiet2;
	endproperty
	a_quiet: assert property (p_quiet) else $error("early item");
	property p_rise;
		$rose(data_valid) |-> $past(bit_tick);
	endproperty
	a_rise: assert property (p_rise) else $error("item no tick");
	property p_sym;
		take |-> mark_symbol != sym_q;
	endproperty
	a_sym: assert property (p_sym) else $error("symbol mark");
	property p_fsym;
		take && mark_frame |-> mark_symbol;
	endproperty
	a_fsym: assert property (p_fsym) else $error("frame mark");
	property p_flen;
		take && mark_frame && seen_q |-> pos_q == 12'h348 || pos_q == 12'h780;
	endproperty
	a_flen: assert property (p_flen) else $error("frame length");
	property p_gzero;
		take && !mark_gate |-> !data_bit;
	endproperty
	a_gzero: assert property (p_gzero) else $error("unsent data");
	property p_ramp;
		take && mark_gate && !gate_q && !mark_frame |-> !data_bit;
	endproperty
	a_ramp: assert property (p_ramp) else $error("slot ramp");
endmodule // tsbf_properties
bind tdma_slot_bit_framer tsbf_properties tsbf_properties_inst (.clk(clk),
	.rst(rst), .bit_tick(bit_tick), .out_ready(out_ready),
	.data_bit(data_bit), .data_valid(data_valid), .mark_frame(mark_frame),
	.mark_gate(mark_gate), .mark_symbol(mark_symbol));

// ==== tb/tsbf_mod_sink.sv ====
// Purpose: modulator stand-in taking framer items
// Assumes: out_ready moves just after the clock edge
// Notes: stall_en refuses three cycles in five
`timescale 1ns/1ps
module tsbf_mod_sink
	import tsbf_pkg::*;
(
	// clock and stall control
	input wire logic clk,
	input wire logic stall_en,
	// framer stream
	input wire logic data_valid,
	input wire logic data_bit,
	input wire logic mark_frame,
	input wire logic mark_gate,
	input wire logic mark_symbol,
	output logic out_ready
);
	logic [ITEM_W-1:0] got_q[$];
	int cyc;
	// take items and pace the ready line
	always @(posedge clk)
	begin
		if (data_valid && out_ready)
			got_q.push_back({mark_frame, mark_gate, mark_symbol, data_bit});
		cyc <= cyc + 1;
		out_ready <= #1 !(stall_en && cyc % 5 < 3);
	end
endmodule // tsbf_mod_sink

// ==== tb/tb.sv ====
// Purpose: self-checking bench for the slot bit framer
// Assumes: a fresh reset before each scenario
// Notes: the expected stream is rebuilt bit by bit
`timescale 1ns/1ps
module tb;
	logic clk, rst, bit_tick, data_bit, data_valid, out_ready;
	logic mark_frame, mark_gate, mark_symbol, stall_en, crc_on;
	logic [3:0] mode_sel;
	logic [8:0] pn9_s;
	logic [14:0] pn15_s;
	logic [15:0] crc_s;
	logic [3:0] exp_q[$];
	int tick_div, cyc, fpos, err_count, tests_run;
	// design and modulator stand-in
	tdma_slot_bit_framer tdma_slot_bit_framer_inst (.clk(clk), .rst(rst),
		.mode_sel(mode_sel), .bit_tick(bit_tick), .out_ready(out_ready),
		.data_bit(data_bit), .data_valid(data_valid),
		.mark_frame(mark_frame), .mark_gate(mark_gate),
		.mark_symbol(mark_symbol));
	tsbf_mod_sink tsbf_mod_sink_inst (.clk(clk), .stall_en(stall_en),
		.data_valid(data_valid), .data_bit(data_bit),
		.mark_frame(mark_frame), .mark_gate(mark_gate),
		.mark_symbol(mark_symbol), .out_ready(out_ready));
	// 250 MHz clock
	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	// one tick every tick_div cycles
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		bit_tick <= #1 (cyc % tick_div == 0);
	end
	// append one expected item, crc runs when enabled
	task automatic put(input logic b, input logic g);
		logic fb;
		fb = crc_s[15] ^ b;
		exp_q.push_back({fpos == 0, g, fpos % 2 == 0, b});
		fpos++;
		if (crc_on)
			crc_s = {crc_s[14:0], 1'b0} ^ (fb ? 16'h1021 : 16'h0000);
	endtask
	// constant field, msb first
	task automatic fld(input logic [21:0] v, input int n, input logic g);
		for (int i = n - 1; i >= 0; i--)
			put(v[i] & g, g);
	endtask
	// payload bits, sequence held in unsent slots
	task automatic pay(input int n, input logic g);
		for (int i = 0; i < n; i++)
		begin
			put(pn9_s[8] & g, g);
			if (g)
				pn9_s = {pn9_s[7:0], pn9_s[8] ^ pn9_s[4]};
		end
	endtask
	// one slot; g high when the slot is sent
	task automatic slot(input int m, input int s, input logic g);
		fld(22'h0, 4, g);
		fld(22'h2, 2, g);
		if (m > 4)
		begin
			fld(22'h19, 6, g);
			fld(m == 5 ? 22'h3D4C : 22'hE149, 16, g);
			crc_s = 16'hFFFF;
			crc_on = 1'b1;
			fld(22'h8000, 20, g);
			pay(160, g);
			crc_on = 1'b0;
			fld({6'h00, ~crc_s}, 16, g);
			fld(22'h0, 16, g);
		end
		else
		begin
			pay(112, g);
			fld(m == 4 ? 22'h785B4 : s == 0 ? 22'h87A4B : s == 1 ? 22'h9D236
				: 22'h81D75, 20, g);
			fld(22'h0, 8, g);
			fld(22'h0, m == 0 ? 22 : 0, g);
			pay(m == 4 ? 116 : 112, g);
			fld(22'h3FFFFF, m == 0 || m == 4 ? 0 : 22, g);
			fld(22'h0, m == 4 ? 18 : 0, g);
		end
	endtask
	// one frame, or one 1920-bit block unframed
	task automatic frame(input int m);
		fpos = 0;
		if (m < 5)
			for (int s = 0; s < 3; s++)
				slot(m, s, (m == 0 || m == 4) ? s == 0 : s < m);
		else if (m < 7)
			for (int s = 0; s < 8; s++)
				slot(m, s, s == (m == 5 ? 4 : 0));
		else
			for (int i = 0; i < 1920; i++)
			begin
				put(m == 7 ? pn9_s[8] : m == 8 ? pn15_s[14] : 1'b0, 1'b1);
				pn9_s = m == 7 ? {pn9_s[7:0], pn9_s[8] ^ pn9_s[4]} : pn9_s;
				pn15_s = m == 8 ? {pn15_s[13:0], pn15_s[14] ^ pn15_s[13]}
					: pn15_s;
			end
	endtask
	// reset into mode m and build n frames of it
	task automatic start(input int m, input int n);
		@(posedge clk);
		#1;
		mode_sel = m[3:0];
		rst = 1'b1;
		repeat (2) @(posedge clk);
		#1;
		rst = 1'b0;
		tsbf_mod_sink_inst.got_q.delete();
		exp_q.delete();
		pn9_s = 9'h1FF;
		pn15_s = 15'h7FFF;
		repeat (n) frame(m);
	endtask
	// wait for n items and compare them in order
	task automatic check(input int n);
		int k;
		k = 0;
		while (tsbf_mod_sink_inst.got_q.size() < n && k < 20 * n)
		begin
			@(posedge clk);
			k++;
		end
		for (int i = 0; i < n; i++)
		begin
			tests_run++;
			if (tsbf_mod_sink_inst.got_q[i] !== exp_q[i])
			begin
				err_count++;
				$display("[FAIL] item %0d expected %h seen %h", i, exp_q[i],
					tsbf_mod_sink_inst.got_q[i]);
				break;
			end
		end
	endtask
	// downlink traffic, two frames
	task automatic t_pdc_traffic;
		start(0, 2);
		check(1680);
	endtask
	// every other mode, two frames each; code 10 acts as zeros
	task automatic t_all_modes;
		for (int m = 1; m < 11; m++)
		begin
			start(m, 2);
			if (m < 5)
				check(1680);
			else
				check(3840);
		end
	endtask
	// modulator stalls while ticks keep coming
	task automatic t_stall;
		stall_en = 1'b1;
		start(3, 1);
		check(840);
		stall_en = 1'b0;
	endtask
	// slow ticks, mode change taken at frame end
	task automatic t_mode_change;
		tick_div = 3;
		start(0, 1);
		frame(9);
		repeat (100) @(posedge clk);
		#1;
		mode_sel = 4'h9;
		check(2760);
		tick_div = 1;
	endtask
	// verdict and end of run
	task automatic tally_and_finish;
		if (err_count == 0 && tests_run > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// cut a hang short
	initial
	begin
		repeat (80000) @(posedge clk);
		err_count++;
		tally_and_finish();
	end
	// main sequence
	initial
	begin
		rst = 1'b1;
		mode_sel = 4'h0;
		stall_en = 1'b0;
		crc_on = 1'b0;
		tick_div = 1;
		repeat (16) @(posedge clk);
		t_pdc_traffic();
		t_all_modes();
		t_stall();
		t_mode_change();
		tally_and_finish();
	end
endmodule // tb
